// ---- rtl/unit_trigger_and_read.sv ----
/*
  Instruction engine that triggers a waiting sequence task in a bus
  motion unit, or reads a block of words from a unit's memory into
  a local destination store, reporting error and equals flags.
  Assumes an APB master on pclk and unit-side logic on the same clock
  that answers status in the same cycle the selection is presented and read data one
  cycle after a read strobe.
*/
module unit_trigger_and_read
  import unit_pkg::*;
#(
  parameter int CYC = CTRL_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // unit side
  output unit_sel_t        unit_sel,
  output logic       [7:0] unit_task,
  input  wire unit_stat_t  unit_stat,
  output logic             unit_trig,
  output logic             unit_rd,
  output logic [MEM_AW-1:0] unit_raddr,
  input  wire logic [WORD_W-1:0] unit_rdata,
  // flags
  output logic             err_flag,
  output logic             eq_flag,
  output logic             dup_flag,
  output logic             busy
);

  eng_state_t        state_r;
  eng_state_t        state_nxt;
  logic [31:0]       trig_op_r;
  logic [31:0]       read_op_r;
  logic [31:0]       cfg_r;
  logic [MEM_AW-1:0] dst_r;
  logic              is_read_r;
  logic              intr_r;
  flags_t            pend_r;
  logic [7:0]        idx_r;
  logic              used_r;
  logic              ctl_tick;
  logic [WORD_W-1:0] mem_rdata;

  // apb decode
  logic        acc;
  logic        wr_en;
  logic        mem_hit;
  logic        addr_ok;
  logic [31:0] rd_word;

  assign acc     = psel && penable && !pready;
  assign wr_en   = psel && penable && pwrite && pready;
  assign mem_hit = (paddr[11:9] == MEM_WIN) && (paddr[1:0] == 2'b00);

  always_comb begin
    addr_ok = 1'b1;
    rd_word = ZERO_WORD;
    unique case (paddr)
      REG_CMD:  rd_word = ZERO_WORD;
      REG_TRIG: rd_word = trig_op_r;
      REG_READ: rd_word = read_op_r;
      REG_CFG:  rd_word = cfg_r;
      REG_STAT: rd_word = {28'h000_0000, dup_flag, busy,
                           eq_flag, err_flag};
      REG_DST:  rd_word = {25'h000_0000, dst_r};
      default: begin
        addr_ok = mem_hit && !pwrite;
        rd_word = mem_hit ? {16'h0000, mem_rdata} : ZERO_WORD;
      end
    endcase
  end

  // one wait state so the store's registered data can be returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= ZERO_WORD;
    end else begin
      pready  <= acc;
      pslverr <= acc && !addr_ok;
      if (acc && !pwrite) begin
        prdata <= addr_ok ? rd_word : ZERO_WORD;
      end
    end
  end

  // operand registers are frozen while an instruction runs
  logic idle;
  logic cmd_wr;
  assign idle   = (state_r == S_IDLE);
  assign cmd_wr = wr_en && (paddr == REG_CMD) && idle &&
                  (pwdata[CMD_TRIG] || pwdata[CMD_READ]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_op_r <= ZERO_WORD;
      read_op_r <= ZERO_WORD;
      cfg_r     <= ZERO_WORD;
      dst_r     <= '0;
    end else if (wr_en && idle) begin
      if (paddr == REG_TRIG) begin
        trig_op_r <= pwdata;
      end
      if (paddr == REG_READ) begin
        read_op_r <= pwdata;
      end
      if (paddr == REG_CFG) begin
        cfg_r <= pwdata;
      end
      if (paddr == REG_DST) begin
        dst_r <= pwdata[MEM_AW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_read_r <= 1'b0;
      intr_r    <= 1'b0;
    end else if (cmd_wr) begin
      is_read_r <= pwdata[CMD_READ];
      intr_r    <= pwdata[CMD_INTR];
    end
  end

  // operand fields
  logic [15:0] code;
  logic [15:0] cnt;
  logic [15:0] task_no;
  logic        code_bus;
  logic        code_sio;
  logic        cnt_ok;
  logic        task_ok;
  logic [15:0] cyc_mask;
  logic        cyc_hit;

  // trigger: C = task, C+1 = unit; read: S+1 = count, S = unit
  assign task_no  = trig_op_r[15:0];
  assign code     = is_read_r ? read_op_r[15:0]
                              : trig_op_r[31:16];
  assign cnt      = read_op_r[31:16];
  assign code_bus = (code >= BUS_CODE_BASE) &&
                    (code <= BUS_CODE_LAST);
  assign code_sio = (code <= SIO_CODE_LAST);
  assign cnt_ok   = (cnt >= CNT_MIN) && (cnt <= CNT_MAX);
  assign task_ok  = (task_no >= TASK_MIN) && (task_no <= TASK_MAX);
  assign cyc_mask = cfg_r[CFG_CYC_LSB +: 16];
  assign cyc_hit  = code_bus && cyc_mask[code[3:0]];

  // evaluation of one execution
  logic ev_err;
  logic ev_eq;
  logic ev_dup;
  logic ev_trig;
  logic ev_read;

  always_comb begin
    ev_err  = 1'b0;
    ev_eq   = 1'b0;
    ev_dup  = 1'b0;
    ev_trig = 1'b0;
    ev_read = 1'b0;
    if (!is_read_r) begin
      if (!code_bus || !unit_stat.present || !unit_stat.motion) begin
        ev_err = 1'b1;
      end else if (intr_r && cyc_hit) begin
        ev_dup = 1'b1;
      end else if (!unit_stat.init && task_ok && unit_stat.task_wait &&
                   unit_stat.ready && !used_r) begin
        ev_trig = 1'b1;
        ev_eq   = 1'b1;
      end
    end else begin
      if (!cnt_ok || !(code_bus || code_sio)) begin
        ev_err = 1'b1;
      end else if (code_bus && !cfg_r[CFG_BUSRD]) begin
        ev_err = 1'b1;
      end else if (!unit_stat.present || unit_stat.remote ||
                   !unit_stat.rd_ok) begin
        ev_err = 1'b1;
      end else if (intr_r && cyc_hit) begin
        ev_dup = 1'b1;
      end else if (!unit_stat.busy) begin
        ev_read = 1'b1;
      end
    end
  end

  // engine sequencing
  logic last_word;
  assign last_word = (idx_r == (cnt[7:0] - 8'h01));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (cmd_wr) begin
        state_nxt = S_LOOK;
      end
      S_LOOK:  state_nxt = S_EVAL;
      S_EVAL:  state_nxt = ev_read ? S_RADDR : S_FIN;
      S_RADDR: state_nxt = S_RDATA;
      S_RDATA: state_nxt = last_word ? S_FIN : S_RADDR;
      S_FIN:   state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // registered copy of the running state, high exactly when not idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_nxt != S_IDLE);
    end
  end

  // unit selection presented before status is judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_sel  <= '0;
      unit_task <= '0;
    end else if (state_r == S_LOOK) begin
      unit_sel.is_bus <= code_bus;
      unit_sel.num    <= code_bus ? {3'b000, code[3:0]} : code[6:0];
      unit_task       <= task_no[7:0];
    end
  end

  // trigger strobe and per-control-cycle acceptance
  tick_div #(
    .N (CYC)
  ) u_ctl_div (
    .clk   (pclk),
    .rst_n (presetn),
    .tick  (ctl_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_trig <= 1'b0;
    end else begin
      unit_trig <= (state_r == S_EVAL) && ev_trig;
    end
  end

  // a trigger in the tick cycle counts against the new control cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used_r <= 1'b0;
    end else if (unit_trig) begin
      used_r <= 1'b1;
    end else if (ctl_tick) begin
      used_r <= 1'b0;
    end
  end

  // word copy from the unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_rd    <= 1'b0;
      unit_raddr <= '0;
      idx_r      <= '0;
    end else begin
      unit_rd    <= (state_nxt == S_RADDR);
      // request address equals the capture index; both step together after each captured word
      if (state_r == S_EVAL) begin
        idx_r      <= '0;
        unit_raddr <= '0;
      end else if (state_r == S_RDATA) begin
        idx_r      <= idx_r + 8'h01;
        unit_raddr <= idx_r[MEM_AW-1:0] + 1'b1;
      end
    end
  end

  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  assign mem_we    = (state_r == S_RDATA);
  assign mem_waddr = dst_r + idx_r[MEM_AW-1:0];

  dest_mem #(
    .W  (WORD_W),
    .AW (MEM_AW)
  ) u_dest (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (unit_rdata),
    .re    (psel && !penable),
    .raddr (paddr[MEM_AW+1:2]),
    .rdata (mem_rdata)
  );

  // pending result, published in one step at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
    end else if (state_r == S_EVAL) begin
      pend_r.err <= ev_err;
      pend_r.eq  <= ev_eq;
    end else if (state_r == S_RDATA && last_word) begin
      pend_r.eq  <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
      eq_flag  <= 1'b0;
    end else if (state_r == S_FIN) begin
      err_flag <= pend_r.err;
      eq_flag  <= pend_r.eq;
    end
  end

  // duplicate refresh is sticky; write one to clear, a new event wins
  logic dup_clr;
  assign dup_clr = wr_en && (paddr == REG_STAT) && pwdata[STAT_DUP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dup_flag <= 1'b0;
    end else if ((state_r == S_EVAL) && ev_dup) begin
      dup_flag <= 1'b1;
    end else if (dup_clr) begin
      dup_flag <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_word;
    (state_r == S_RADDR) ##1 (state_r == S_RDATA);
  endsequence

  sequence s_bad_trig;
    (state_r == S_EVAL) && !is_read_r && !code_bus;
  endsequence

  chk_trig_task: assert property (
    unit_trig |-> (unit_task != 8'h00) && $past(ev_eq)
  ) else $error("trigger issued with bad task or no equals");

  // triggers seen since the last control tick, kept apart from used_r
  logic trig_seen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_seen_r <= 1'b0;
    end else if (unit_trig) begin
      trig_seen_r <= 1'b1;
    end else if (ctl_tick) begin
      trig_seen_r <= 1'b0;
    end
  end

  chk_one_per_cycle: assert property (
    unit_trig |-> !trig_seen_r
  ) else $error("two triggers in one control cycle");

  chk_bad_code_err: assert property (
    s_bad_trig |-> ##2 err_flag && !eq_flag
  ) else $error("bad unit code did not set error");

  chk_init_block: assert property (
    (state_r == S_EVAL) && !is_read_r && unit_stat.init
    |=> !unit_trig ##2 !eq_flag
  ) else $error("trigger ran while unit initializing");

  chk_dup_sets: assert property (
    (state_r == S_EVAL) && intr_r && cyc_hit && !ev_err
    |=> dup_flag && !unit_trig && !unit_rd
  ) else $error("duplicate refresh not flagged");

  chk_count_err: assert property (
    (state_r == S_EVAL) && is_read_r && !cnt_ok |-> ##2 err_flag
  ) else $error("bad word count did not set error");

  chk_busy_skip: assert property (
    (state_r == S_EVAL) && is_read_r && unit_stat.busy
    |=> !unit_rd ##1 !eq_flag
  ) else $error("busy unit read was not skipped");

  chk_read_done: assert property (
    s_word ##0 last_word |-> ##2 eq_flag && !err_flag
  ) else $error("completed read left equals clear");

  chk_flag_pair: assert property (
    ($changed(err_flag) || $changed(eq_flag)) |-> $past(state_r == S_FIN)
  ) else $error("flags changed outside end of execution");

  chk_word_dest: assert property (
    mem_we |-> mem_waddr == dst_r + unit_raddr
  ) else $error("read word stored at wrong destination");

  chk_bus_read_off: assert property (
    (state_r == S_EVAL) && is_read_r && cnt_ok && code_bus &&
    !cfg_r[CFG_BUSRD] |=> !unit_rd ##1 err_flag
  ) else $error("bus unit read not refused");

endmodule

// ---- rtl/unit_pkg.sv ----
/*
  Shared constants and types for the unit trigger and read engine:
  register map, field positions, operand ranges and engine states.
  Assumes a single 250 MHz clock domain.
*/
package unit_pkg;
  localparam int CLK_NS        = 4;
  localparam int CTRL_CYCLE_NS = 1000;
  localparam int CTRL_CYCLES   =
    (CTRL_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WORD_W        = 16;
  localparam int MEM_DEPTH     = 128;
  localparam int MEM_AW        = 7;

  // register byte offsets
  localparam logic [11:0] REG_CMD  = 12'h000;
  localparam logic [11:0] REG_TRIG = 12'h004;
  localparam logic [11:0] REG_READ = 12'h008;
  localparam logic [11:0] REG_CFG  = 12'h00C;
  localparam logic [11:0] REG_STAT = 12'h010;
  localparam logic [11:0] REG_DST  = 12'h014;
  localparam logic [2:0]  MEM_WIN  = 3'h1;

  // bit positions
  localparam int CMD_TRIG    = 0;
  localparam int CMD_READ    = 1;
  localparam int CMD_INTR    = 2;
  localparam int STAT_ERR    = 0;
  localparam int STAT_EQ     = 1;
  localparam int STAT_BUSY   = 2;
  localparam int STAT_DUP    = 3;
  localparam int CFG_BUSRD   = 0;
  localparam int CFG_CYC_LSB = 16;

  // operand ranges
  localparam logic [15:0] TASK_MIN      = 16'h0001;
  localparam logic [15:0] TASK_MAX      = 16'h00FF;
  localparam logic [15:0] BUS_CODE_BASE = 16'h8000;
  localparam logic [15:0] BUS_CODE_LAST = 16'h800F;
  localparam logic [15:0] SIO_CODE_LAST = 16'h005F;
  localparam logic [15:0] CNT_MIN       = 16'h0001;
  localparam logic [15:0] CNT_MAX       = 16'h0080;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  typedef struct packed {
    logic present;
    logic motion;
    logic rd_ok;
    logic remote;
    logic busy;
    logic ready;
    logic init;
    logic task_wait;
  } unit_stat_t;

  typedef struct packed {
    logic       is_bus;
    logic [6:0] num;
  } unit_sel_t;

  typedef struct packed {
    logic err;
    logic eq;
  } flags_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_LOOK  = 6'b000010,
    S_EVAL  = 6'b000100,
    S_RADDR = 6'b001000,
    S_RDATA = 6'b010000,
    S_FIN   = 6'b100000
  } eng_state_t;
endpackage

// ---- rtl/tick_div.sv ----
/*
  Free-running divider giving a one-cycle enable every N clocks.
  Assumes N of at least 2 and one clock domain.
*/
module tick_div #(
  parameter int N = 250
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int CW = $clog2(N);
  localparam logic [CW-1:0] LAST = CW'(N - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

// ---- rtl/dest_mem.sv ----
/*
  Destination word store: one write port, one read port, read data
  from a register one cycle after the address. No reset on contents.
*/
module dest_mem #(
  parameter int W  = 16,
  parameter int AW = 7
) (
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ---- bench/unit_model.sv ----
/*
  Behavioural far-side unit: status of the selected unit, word
  memory answering reads, and a log of accepted triggers.
  Assumes the engine's clock and a bench that sets the status.
*/
module unit_model
  import unit_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // engine side
  input  wire unit_sel_t         unit_sel,
  input  wire logic [7:0]        unit_task,
  input  wire logic              unit_trig,
  input  wire logic              unit_rd,
  input  wire logic [MEM_AW-1:0] unit_raddr,
  output unit_stat_t             unit_stat,
  output logic [WORD_W-1:0]      unit_rdata,
  // bench side
  input  wire unit_stat_t        stat_set,
  output logic [7:0]             trig_count,
  output logic [7:0]             last_task
);
  // busy, init, ready and task waiting are set by the bench
  assign unit_stat = stat_set;

  // word i holds select code and index; toggles when not answering
  // so a late sample never matches by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_rdata <= 16'h0000;
    end else if (unit_rd) begin
      unit_rdata <= {unit_sel, 1'b0, unit_raddr};
    end else begin
      unit_rdata <= ~unit_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_count <= 8'h00;
      last_task  <= 8'h00;
    end else if (unit_trig) begin
      trig_count <= trig_count + 8'h01;
      last_task  <= unit_task;
    end
  end
endmodule

// ---- bench/test_unit_trigger_and_read.sv ----
/*
  Self-checking bench for the trigger and read engine: APB master
  tasks, unit model, one task per scenario.
  Assumes the unit model is compiled before this file.
*/
module test_unit_trigger_and_read
  import unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          CYC_T    = 250;
  localparam unit_stat_t  GOOD     = 8'he5;
  localparam logic [31:0] DO_TRIG  = 32'h0000_0001;
  localparam logic [31:0] DO_READ  = 32'h0000_0002;
  localparam logic [31:0] DO_ITRIG = 32'h0000_0005;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  unit_sel_t         unit_sel;
  logic [7:0]        unit_task;
  unit_stat_t        unit_stat;
  unit_stat_t        stat_set;
  logic              unit_trig;
  logic              unit_rd;
  logic [MEM_AW-1:0] unit_raddr;
  logic [WORD_W-1:0] unit_rdata;
  logic              err_flag;
  logic              eq_flag;
  logic              dup_flag;
  logic              busy;
  logic [7:0]        trig_count;
  logic [7:0]        last_task;
  int                num_errors;
  int                check_count;

  unit_trigger_and_read #(.CYC(CYC_T)) unit_trigger_and_read_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .unit_sel, .unit_task, .unit_stat,
    .unit_trig, .unit_rd, .unit_raddr, .unit_rdata, .err_flag,
    .eq_flag, .dup_flag, .busy
  );
  unit_model unit_model_inst (
    .pclk, .presetn, .unit_sel, .unit_task, .unit_trig, .unit_rd,
    .unit_raddr, .unit_stat, .unit_rdata, .stat_set, .trig_count,
    .last_task
  );

  always #2 pclk = ~pclk;

  task automatic chk_bit(input string w, input logic x, input logic g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", w, x, g);
    end
  endtask

  task automatic chk_word(input string w, input logic [31:0] x,
                          input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", w, x, g);
    end
  endtask

  // one idle cycle after each transfer keeps psel from toggling twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk_bit("pready", 1'b1, pready);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk_bit("pslverr", 1'b0, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, ZERO_WORD, q, e);
    chk_bit("pslverr", 1'b0, e);
  endtask

  task automatic exec(input logic [31:0] cmd, output logic [31:0] q);
    int n;
    wr(REG_CMD, cmd);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    rd(REG_STAT, q);
  endtask

  task automatic run(input logic [31:0] cmd, input logic err,
                     input logic eq);
    logic [31:0] q;
    logic [7:0]  tc;
    tc = trig_count;
    exec(cmd, q);
    chk_bit("err_flag", err, err_flag);
    chk_bit("eq_flag", eq, eq_flag);
    chk_word("stat", {29'h0, 1'b0, eq, err}, {29'h0, q[2:0]});
    tc = tc + {7'h0, cmd[CMD_TRIG] & ~cmd[CMD_READ] & eq};
    chk_word("triggers", {24'h0, tc}, {24'h0, trig_count});
  endtask

  // waits a full control cycle so no earlier trigger interferes
  task automatic cs(input logic [31:0] cmd, input logic [11:0] a,
                    input logic [31:0] op, input unit_stat_t st,
                    input logic err, input logic eq);
    repeat (CYC_T) @(posedge pclk);
    stat_set <= st;
    wr(a, op);
    run(cmd, err, eq);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(REG_STAT, q);
    chk_word("stat after reset", ZERO_WORD, q);
    apb(1'b0, 12'h018, ZERO_WORD, q, e);
    chk_bit("unmapped pslverr", 1'b1, e);
    chk_word("unmapped data", ZERO_WORD, q);
    apb(1'b1, 12'h200, 32'h0000_1234, q, e);
    chk_bit("window write pslverr", 1'b1, e);
  endtask

  task automatic t_limit();
    logic [31:0] q;
    int          n;
    wr(REG_TRIG, 32'h8003_0001);
    run(DO_TRIG, 1'b0, 1'b1);
    chk_word("task", 32'h0000_0001, {24'h0, last_task});
    wr(REG_TRIG, 32'h8003_0002);
    run(DO_TRIG, 1'b0, 1'b0);
    n = 0;
    do begin
      exec(DO_TRIG, q);
      n++;
    end while (q[STAT_EQ] !== 1'b1 && n < 40);
    chk_bit("retry accepted", 1'b1, q[STAT_EQ]);
    chk_word("task", 32'h0000_0002, {24'h0, last_task});
  endtask

  task automatic t_trig();
    cs(DO_TRIG, REG_TRIG, 32'h0003_0001, GOOD, 1'b1, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8010_0001, GOOD, 1'b1, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0001, 8'h65, 1'b1, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0001, 8'ha5, 1'b1, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0001, 8'he7, 1'b0, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0000, GOOD, 1'b0, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0100, GOOD, 1'b0, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0001, 8'he4, 1'b0, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h8003_0001, 8'he1, 1'b0, 1'b0);
    cs(DO_TRIG, REG_TRIG, 32'h800F_00FF, GOOD, 1'b0, 1'b1);
  endtask

  task automatic t_read();
    logic [31:0] q;
    int          n;
    wr(REG_CFG, 32'h0000_0001);
    cs(DO_READ, REG_READ, 32'h0001_005F, GOOD, 1'b0, 1'b1);
    cs(DO_READ, REG_READ, 32'h0000_0005, GOOD, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0081_0005, GOOD, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0004_0060, GOOD, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0004_8010, GOOD, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0004_0005, 8'hf5, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0004_0005, 8'hc5, 1'b1, 1'b0);
    cs(DO_READ, REG_READ, 32'h0004_0005, 8'hed, 1'b0, 1'b0);
    stat_set <= GOOD;
    n = 0;
    do begin
      exec(DO_READ, q);
      n++;
    end while (q[STAT_EQ] !== 1'b1 && n < 4);
    chk_bit("read retry", 1'b1, q[STAT_EQ]);
    wr(REG_CFG, ZERO_WORD);
    cs(DO_READ, REG_READ, 32'h0004_8002, GOOD, 1'b1, 1'b0);
  endtask

  task automatic t_dup();
    logic [31:0] q;
    wr(REG_CFG, 32'h0008_0000);
    cs(DO_ITRIG, REG_TRIG, 32'h8003_0001, GOOD, 1'b0, 1'b0);
    chk_bit("dup_flag", 1'b1, dup_flag);
    rd(REG_STAT, q);
    chk_bit("stat dup", 1'b1, q[STAT_DUP]);
    wr(REG_STAT, 32'h0000_0008);
    chk_bit("dup cleared", 1'b0, dup_flag);
    cs(DO_ITRIG, REG_TRIG, 32'h8004_0001, GOOD, 1'b0, 1'b1);
    chk_bit("dup quiet", 1'b0, dup_flag);
  endtask

  // start near the top of the store so the block wraps
  task automatic t_data();
    logic [31:0] q;
    logic [6:0]  k;
    wr(REG_CFG, 32'h0000_0001);
    wr(REG_DST, 32'h0000_007E);
    cs(DO_READ, REG_READ, 32'h0080_800F, GOOD, 1'b0, 1'b1);
    for (int i = 0; i < 128; i++) begin
      k = 7'h7E + 7'(i);
      rd(12'h200 + {3'h0, k, 2'h0}, q);
      chk_word("dest word", {16'h0, 8'h8F, 1'b0, 7'(i)}, q);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    pclk     = 1'b0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = ZERO_WORD;
    stat_set = GOOD;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_limit();
    t_trig();
    t_read();
    t_dup();
    t_data();
    summarize();
  end
endmodule
